// [hdl/rsp_defs.svh]
// constants of the serial slave port of the clock module
// assumes inclusion by bare name from every file that needs them
`ifndef RSP_DEFS_SVH
`define RSP_DEFS_SVH

// command byte layout
`define RSP_CMD_DIR_BIT       7
`define RSP_CMD_BANK_HI       6
`define RSP_CMD_BANK_LO       3
`define RSP_CMD_IDX_HI        2
`define RSP_CMD_IDX_LO        0
`define RSP_DIR_READ          1'h1
`define RSP_DIR_WRITE         1'h0

// byte framing
`define RSP_BYTE_BITS         8
`define RSP_LAST_BIT          3'h7
`define RSP_FIRST_BIT         3'h0
`define RSP_IDX_STEP          3'h1

// cached area: banks holding watch, alarm, timer and temperature
`define RSP_REGS_PER_BANK     8
`define RSP_CACHE_BASE_BANK   5'h01
`define RSP_CACHE_BANKS       4

// reset and fill values
`define RSP_OUT_RESET         8'h00
`define RSP_MISS_DATA         8'h00
`define RSP_BANK_TOP_BIT      1'h0

`endif

// [hdl/rsp_pkg.sv]
// types shared by the serial slave port files
// assumes rsp_defs.svh is on the include path
package rsp_pkg;

  // command byte as it arrives on the serial line, msb first
  typedef struct packed {
    logic       dir;
    logic [3:0] bank_select_field;
    logic [2:0] register_index_field;
  } rsp_cmd_t;

  // copy-back write toward the live register file
  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } rsp_wr_t;

  // cache housekeeping in the system clock domain
  typedef enum logic [2:0] {
    RSP_IDLE = 3'b001,
    RSP_SNAP = 3'b010,
    RSP_WB   = 3'b100
  } rsp_state_t;

endpackage

// [hdl/rsp_cache_mem.sv]
// small two-clock byte memory used as the transfer cache
// assumes one writer clock and one reader clock; read data registered
`timescale 1ns/100ps

module rsp_cache_mem #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic             wr_clk,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic             rd_clk,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // reader only looks at words the writer left alone long before
  always_ff @(posedge rd_clk) begin
    rd_data <= mem_q[rd_addr];
  end

endmodule

// [hdl/rsp_spi_port.sv]
// serial slave port: shift logic on the serial clock, cache upkeep on SYS_CLK
// assumes a live register file answering REG_RD_ADDR in the same cycle
// and taking REG_WR writes; SPI pins come straight from the package balls
`timescale 1ns/100ps

`include "rsp_defs.svh"

module rsp_spi_port
  import rsp_pkg::*;
#(
  parameter int unsigned CACHE_BANKS = `RSP_CACHE_BANKS,
  parameter logic [4:0]  BASE_BANK   = `RSP_CACHE_BASE_BANK
) (
  input  wire logic       SYS_CLK,
  input  wire logic       SYS_RST,
  input  wire logic       SPI_SCL,
  input  wire logic       SPI_CE,
  input  wire logic       SERIAL_IN_PIN,
  output logic            SERIAL_OUT_PIN,
  output logic            SERIAL_OUT_OE,
  output logic      [7:0] REG_RD_ADDR,
  input  wire logic [7:0] REG_RD_DATA,
  output rsp_wr_t         REG_WR,
  output logic            CACHE_BUSY
);

  localparam int unsigned DEPTH = CACHE_BANKS * `RSP_REGS_PER_BANK;
  localparam int unsigned AW    = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [7:0] BASE_ADDR = {BASE_BANK, 3'h0};

  ////////////////////////////////////////////////////////////////////////////
  // link side declarations

  logic [2:0]    bit_q;
  logic [6:0]    sh_q;
  logic          cmd_done_q;
  logic          dir_q;
  logic [4:0]    bank_q;
  logic [2:0]    idx_q;
  logic          rd_ok_q;
  logic [7:0]    out_q;
  logic          oe_q;
  logic [DEPTH-1:0] dirty_q;
  logic          tog_q;

  logic          byte_end;
  logic [7:0]    rx_byte;
  rsp_cmd_t      cmd_in;
  logic [4:0]    cmd_bank;
  logic [4:0]    lk_rd_bank;
  logic [2:0]    lk_rd_idx;
  logic [AW-1:0] lk_rd_addr;
  logic [AW-1:0] lk_wr_addr;
  logic          lk_wr_en;
  logic [7:0]    snap_rd;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_cache(input logic [4:0] bank);
    logic [5:0] top;
    top = {1'b0, BASE_BANK} + 6'(CACHE_BANKS);
    return (bank >= BASE_BANK) && ({1'b0, bank} < top);
  endfunction

  function automatic logic [AW-1:0] cache_idx(input logic [4:0] bank,
                                              input logic [2:0] idx);
    logic [4:0] rel;
    rel = bank - BASE_BANK;
    return AW'({rel, idx});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link side: receive path

  assign rx_byte  = {sh_q, SERIAL_IN_PIN};
  assign cmd_in   = rsp_cmd_t'(rx_byte);
  assign byte_end = (bit_q == `RSP_LAST_BIT);
  assign cmd_bank = {`RSP_BANK_TOP_BIT, cmd_in.bank_select_field};

  // chip enable low is the link reset
  always_ff @(posedge SPI_SCL or negedge SPI_CE) begin
    if (!SPI_CE) begin
      bit_q <= `RSP_FIRST_BIT;
      sh_q  <= 7'h00;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= rx_byte[6:0];
    end
  end

  // command only taken inside an enabled frame
  always_ff @(posedge SPI_SCL or negedge SPI_CE) begin
    if (!SPI_CE) begin
      cmd_done_q <= 1'b0;
      dir_q      <= `RSP_DIR_WRITE;
      bank_q     <= 5'h00;
    end else if (!cmd_done_q && byte_end) begin
      cmd_done_q <= 1'b1;
      dir_q      <= cmd_in.dir;
      bank_q     <= cmd_bank;
    end
  end

  always_ff @(posedge SPI_SCL or negedge SPI_CE) begin
    if (!SPI_CE) begin
      idx_q <= 3'h0;
    end else if (byte_end) begin
      idx_q <= cmd_done_q ? idx_q + `RSP_IDX_STEP : cmd_in.register_index_field;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side: cache access

  // next byte to send is fetched on the edge that closes the current one
  assign lk_rd_bank = cmd_done_q ? bank_q : cmd_bank;
  assign lk_rd_idx  = cmd_done_q ? idx_q + `RSP_IDX_STEP : cmd_in.register_index_field;
  assign lk_rd_addr = cache_idx(lk_rd_bank, lk_rd_idx);

  // reads served from the snapshot for cached banks, as RSP_MISS_DATA otherwise
  always_ff @(posedge SPI_SCL or negedge SPI_CE) begin
    if (!SPI_CE) begin
      rd_ok_q <= 1'b0;
    end else if (byte_end) begin
      rd_ok_q <= in_cache(lk_rd_bank);
    end
  end

  // writes to cached banks land in a separate write cache, never in the snapshot
  assign lk_wr_en   = cmd_done_q && byte_end && (dir_q == `RSP_DIR_WRITE) && in_cache(bank_q);
  assign lk_wr_addr = cache_idx(bank_q, idx_q);

  // survives chip enable low so the system side can copy back;
  // scl may be stopped during reset, hence the asynchronous clear
  // modified bytes tracked
  always_ff @(posedge SPI_SCL or posedge SYS_RST) begin
    if (SYS_RST) begin
      dirty_q <= '0;
      tog_q   <= 1'b0;
    end else if (!cmd_done_q && byte_end && SPI_CE) begin
      dirty_q <= '0;
      tog_q   <= ~tog_q;
    end else if (lk_wr_en && SPI_CE) begin
      dirty_q[lk_wr_addr] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link side: transmit path

  always_ff @(negedge SPI_SCL or negedge SPI_CE) begin
    if (!SPI_CE) begin
      out_q <= `RSP_OUT_RESET;
      oe_q  <= 1'b0;
    end else if (cmd_done_q && (dir_q == `RSP_DIR_READ)) begin
      oe_q <= 1'b1;
      if (bit_q == `RSP_FIRST_BIT) begin
        out_q <= rd_ok_q ? snap_rd : `RSP_MISS_DATA;
      end else begin
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  assign SERIAL_OUT_PIN = out_q[7];
  assign SERIAL_OUT_OE  = oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // system side declarations

  logic             ce_s1_q;
  logic             ce_s2_q;
  logic             ce_p_q;
  logic             tog_s1_q;
  logic             tog_s2_q;
  logic             tog_seen_q;
  logic [DEPTH-1:0] dirty_s1_q;
  logic [DEPTH-1:0] dirty_s2_q;
  logic             snap_pend_q;
  logic             wb_pend_q;
  logic             wb_go_q;
  logic             wb_v_q;
  logic [AW-1:0]    wb_a_q;
  logic [AW-1:0]    cnt_q;
  rsp_state_t       state_q;
  logic             ce_rise;
  logic             ce_fall;
  logic             take_wb;
  logic             take_snap;
  logic [7:0]       wr_rd;

  ////////////////////////////////////////////////////////////////////////////
  // system side: crossings

  // dirty and toggle are quiet by the time chip enable is seen low
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ce_s1_q    <= 1'b0;
      ce_s2_q    <= 1'b0;
      ce_p_q     <= 1'b0;
      tog_s1_q   <= 1'b0;
      tog_s2_q   <= 1'b0;
      dirty_s1_q <= '0;
      dirty_s2_q <= '0;
    end else begin
      ce_s1_q    <= SPI_CE;
      ce_s2_q    <= ce_s1_q;
      ce_p_q     <= ce_s2_q;
      tog_s1_q   <= tog_q;
      tog_s2_q   <= tog_s1_q;
      dirty_s1_q <= dirty_q;
      dirty_s2_q <= dirty_s1_q;
    end
  end

  assign ce_rise   = ce_s2_q && !ce_p_q;
  assign ce_fall   = !ce_s2_q && ce_p_q;
  // copy-back first, so a quick next frame snapshots fresh values
  assign take_wb   = (state_q == RSP_IDLE) && wb_pend_q;
  assign take_snap = (state_q == RSP_IDLE) && !wb_pend_q && snap_pend_q;

  // a new edge wins over the clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      snap_pend_q <= 1'b0;
      wb_pend_q   <= 1'b0;
    end else begin
      snap_pend_q <= ce_rise || (snap_pend_q && !take_snap);
      wb_pend_q   <= ce_fall || (wb_pend_q && !take_wb);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system side: cache upkeep

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_q <= RSP_IDLE;
    end else begin
      unique case (state_q)
        RSP_IDLE: begin
          if (take_wb) begin
            state_q <= RSP_WB;
          end else if (take_snap) begin
            state_q <= RSP_SNAP;
          end
        end
        RSP_SNAP: begin
          if (cnt_q == LAST) begin
            state_q <= RSP_IDLE;
          end
        end
        RSP_WB: begin
          if (cnt_q == LAST) begin
            state_q <= RSP_IDLE;
          end
        end
        default: begin
          state_q <= RSP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || state_q == RSP_IDLE) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + AW'(1);
    end
  end

  // a frame with no command byte leaves nothing to copy back
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      tog_seen_q <= 1'b0;
      wb_go_q    <= 1'b0;
    end else if (take_wb) begin
      tog_seen_q <= tog_s2_q;
      wb_go_q    <= tog_s2_q != tog_seen_q;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      wb_v_q <= 1'b0;
      wb_a_q <= '0;
    end else begin
      wb_v_q <= (state_q == RSP_WB) && wb_go_q && dirty_s2_q[cnt_q];
      wb_a_q <= cnt_q;
    end
  end

  assign REG_RD_ADDR  = BASE_ADDR + 8'(cnt_q);
  assign REG_WR.en    = wb_v_q;
  assign REG_WR.addr  = BASE_ADDR + 8'(wb_a_q);
  assign REG_WR.data  = wr_rd;
  assign CACHE_BUSY   = (state_q != RSP_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // cache memories

  // snapshot written only before the first read
  rsp_cache_mem #(
    .WIDTH (`RSP_BYTE_BITS),
    .DEPTH (DEPTH)
  ) u_snap (
    .wr_clk  (SYS_CLK),
    .wr_en   (state_q == RSP_SNAP),
    .wr_addr (cnt_q),
    .wr_data (REG_RD_DATA),
    .rd_clk  (SPI_SCL),
    .rd_addr (lk_rd_addr),
    .rd_data (snap_rd)
  );

  rsp_cache_mem #(
    .WIDTH (`RSP_BYTE_BITS),
    .DEPTH (DEPTH)
  ) u_wcache (
    .wr_clk  (SPI_SCL),
    .wr_en   (lk_wr_en),
    .wr_addr (lk_wr_addr),
    .wr_data (rx_byte),
    .rd_clk  (SYS_CLK),
    .rd_addr (cnt_q),
    .rd_data (wr_rd)
  );

endmodule

// [sim/rsp_chk_sva.sv]
// port assertions for the serial slave port
// assumes a bind onto rsp_spi_port; link side reset is chip enable low
`timescale 1ns/100ps
module rsp_chk
  import rsp_pkg::*;
#(
  parameter int unsigned CACHE_BANKS = 4,
  parameter logic [4:0]  BASE_BANK   = 5'h01
) (
  input wire logic       SYS_CLK,
  input wire logic       SYS_RST,
  input wire logic       SPI_SCL,
  input wire logic       SPI_CE,
  input wire logic       SERIAL_IN_PIN,
  input wire logic       SERIAL_OUT_PIN,
  input wire logic       SERIAL_OUT_OE,
  input wire logic [7:0] REG_RD_ADDR,
  input wire logic [7:0] REG_RD_DATA,
  input wire rsp_wr_t    REG_WR,
  input wire logic       CACHE_BUSY
);
  localparam logic [7:0] LO = {BASE_BANK, 3'h0};
  localparam logic [7:0] HI = LO + 8'(CACHE_BANKS * 8) - 8'h01;
  logic [4:0] bits_q;
  logic       rd_q;
  logic       hold_q;
  logic [5:0] lo_cnt_q;
  ////////////////////////////////////////////////////////////////////////////////
  // saturating bit count, so long frames never wrap back into a command
  always_ff @(posedge SPI_SCL or negedge SPI_CE) begin
    if (!SPI_CE) begin
      bits_q <= 5'h00;
      rd_q   <= 1'b0;
    end else begin
      if (bits_q == 5'h00) rd_q <= SERIAL_IN_PIN;
      if (bits_q != 5'h1F) bits_q <= bits_q + 5'h01;
    end
  end
  always_ff @(posedge SPI_SCL) hold_q <= SERIAL_OUT_PIN;
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || SPI_CE) lo_cnt_q <= 6'h00;
    else if (lo_cnt_q != 6'h3F) lo_cnt_q <= lo_cnt_q + 6'h01;
  end
  sequence s_cmd_done;
    bits_q == 5'h08;
  endsequence
  sequence s_rd_cmd;
    s_cmd_done ##0 rd_q;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_oe_idle: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !SPI_CE |-> !SERIAL_OUT_OE) else $error("output driven while deselected");
  a_wr_quiet: assert property (@(posedge SPI_SCL) disable iff (!SPI_CE)
    SERIAL_OUT_OE |-> rd_q && bits_q >= 5'h08) else $error("output driven outside read data");
  a_rd_drive: assert property (@(posedge SPI_SCL) disable iff (!SPI_CE)
    s_rd_cmd |-> SERIAL_OUT_OE) else $error("read data not driven");
  a_out_hold: assert property (@(negedge SPI_SCL) disable iff (!SPI_CE)
    SERIAL_OUT_OE |-> SERIAL_OUT_PIN == hold_q) else $error("output moved on rising edge");
  a_snap_busy: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    $rose(SPI_CE) |-> ##[1:6] CACHE_BUSY) else $error("no snapshot at frame start");
  a_snap_range: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    CACHE_BUSY && SPI_CE |-> REG_RD_ADDR inside {[LO:HI]}) else $error("snapshot address");
  a_wb_window: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    REG_WR.en |-> !SPI_CE && lo_cnt_q inside {[6'h02:6'h2D]}) else $error("copy-back timing");
  a_wb_range: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    REG_WR.en |-> $past(CACHE_BUSY) && REG_WR.addr inside {[LO:HI]})
    else $error("copy-back address");
endmodule

// [sim/rsp_master.sv]
// link master model driving chip enable, serial clock and data in
// assumes a 48 ns serial clock that stands low between frames
`timescale 1ns/100ps
module rsp_master (
  output logic      scl,
  output logic      ce,
  output logic      serial_in_pin,
  input  wire logic serial_out_pin,
  input  wire logic sdo_oe
);
  localparam int HALF = 24;
  logic line;
  // undriven output reads as high impedance
  assign line = sdo_oe ? serial_out_pin : 1'bz;
  initial begin
    scl = 1'b0;
    ce  = 1'b0;
    serial_in_pin = 1'b1;
  end
  // frame opens with chip enable high
  task automatic open_frame();
    #3;
    ce <= 1'b1;
    #(HALF);
  endtask
  // msb first, one bit per pulse, data changed while clock low
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      serial_in_pin <= tx[i];
      #(HALF);
      rx[i] = line;
      scl <= 1'b1;
      #(HALF);
      scl <= 1'b0;
    end
  endtask
  // frame ends with chip enable low; data in then toggles
  task automatic close_frame();
    #(HALF);
    ce  <= 1'b0;
    serial_in_pin <= ~serial_in_pin;
  endtask
endmodule

// [sim/rsp_spi_port_tb.sv]
// self-checking bench for the serial slave port
// assumes rsp_master on the link; a live register array answers here
`timescale 1ns/100ps
module rsp_spi_port_tb
  import rsp_pkg::*;
;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       scl;
  logic       ce;
  logic       serial_in_pin;
  logic       serial_out_pin;
  logic       sdo_oe;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  rsp_wr_t    wr;
  logic       busy;
  logic [7:0] live_q [256];
  logic [7:0] wr_log [$];
  int         n_errors = 0;
  int         total_checks = 0;
  int         cyc = 0;
  ////////////////////////////////////////////////////////////////////////////////
  always #4 sys_clk = ~sys_clk;
  assign rd_data = live_q[rd_addr];
  rsp_spi_port rsp_spi_port_inst (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .SPI_SCL(scl),
    .SPI_CE(ce), .SERIAL_IN_PIN(serial_in_pin), .SERIAL_OUT_PIN(serial_out_pin), .SERIAL_OUT_OE(sdo_oe),
    .REG_RD_ADDR(rd_addr), .REG_RD_DATA(rd_data), .REG_WR(wr), .CACHE_BUSY(busy));
  rsp_master rsp_master_inst (.scl(scl), .ce(ce), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .sdo_oe(sdo_oe));
  function automatic logic [7:0] pat(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction
  initial foreach (live_q[i]) live_q[i] = pat(8'(i));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (wr.en === 1'b1) begin
      live_q[wr.addr] <= wr.data;
      wr_log.push_back(wr.addr);
    end
    // a hung run is cut here
    if (cyc == 20000) begin
      n_errors++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // copy-back must be over before a new frame
  task automatic idle_wait();
    repeat (60) @(posedge sys_clk);
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge sys_clk);
    chk({7'h00, busy}, 8'h00, "cache still busy");
  endtask
  task automatic t_wr_wrap();
    logic [7:0] r;
    logic [7:0] v [3] = '{8'hA5, 8'h3C, 8'hC3};
    wr_log.delete();
    rsp_master_inst.open_frame();
    rsp_master_inst.shift(8'h0E, 8, r);
    foreach (v[i]) rsp_master_inst.shift(v[i], 8, r);
    rsp_master_inst.close_frame();
    idle_wait();
    chk(8'(wr_log.size()), 8'h03, "copy-back count");
    chk(live_q[8'h0E], 8'hA5, "index 6");
    chk(live_q[8'h0F], 8'h3C, "index 7");
    chk(live_q[8'h08], 8'hC3, "index wrap");
    chk(live_q[8'h09], pat(8'h09), "untouched byte");
    rsp_master_inst.open_frame();
    rsp_master_inst.shift(8'h8E, 8, r);
    foreach (v[i]) begin
      rsp_master_inst.shift(~v[i], 8, r);
      chk(r, v[i], "read back");
    end
    rsp_master_inst.close_frame();
    idle_wait();
    chk(8'(wr_log.size()), 8'h03, "read frame copied back");
  endtask
  task automatic t_snap();
    logic [7:0] r;
    rsp_master_inst.open_frame();
    rsp_master_inst.shift(8'h92, 8, r);
    // live change lands after the first data byte is fetched and before the second is fetched from the cache
    @(posedge sys_clk);
    live_q[8'h13] <= 8'hFF;
    repeat (8) @(posedge sys_clk);
    rsp_master_inst.shift(8'h00, 8, r);
    chk(r, pat(8'h12), "snapshot first");
    rsp_master_inst.shift(8'h00, 8, r);
    chk(r, pat(8'h13), "snapshot frozen");
    rsp_master_inst.close_frame();
    idle_wait();
    chk(live_q[8'h13], 8'hFF, "live overwritten");
  endtask
  task automatic t_abort();
    logic [7:0] r;
    wr_log.delete();
    rsp_master_inst.open_frame();
    rsp_master_inst.shift(8'hFF, 4, r);
    rsp_master_inst.close_frame();
    idle_wait();
    rsp_master_inst.open_frame();
    rsp_master_inst.shift(8'h18, 8, r);
    rsp_master_inst.shift(8'h77, 8, r);
    rsp_master_inst.shift(8'hFF, 3, r);
    rsp_master_inst.close_frame();
    idle_wait();
    chk(8'(wr_log.size()), 8'h01, "abort copy-back count");
    chk(live_q[8'h18], 8'h77, "byte after abort");
    chk(live_q[8'h19], pat(8'h19), "partial byte kept");
    // bank outside the cached area reads as zero
    rsp_master_inst.open_frame();
    rsp_master_inst.shift(8'h80, 8, r);
    rsp_master_inst.shift(8'hFF, 8, r);
    chk(r, 8'h00, "uncached bank read");
    rsp_master_inst.close_frame();
    idle_wait();
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    t_wr_wrap();
    t_snap();
    t_abort();
    conclude();
  end
endmodule
bind rsp_spi_port rsp_chk #(.CACHE_BANKS(CACHE_BANKS), .BASE_BANK(BASE_BANK)) rsp_chk_inst (
  .SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .SPI_SCL(SPI_SCL), .SPI_CE(SPI_CE),
  .SERIAL_IN_PIN(SERIAL_IN_PIN), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
  .SERIAL_OUT_OE(SERIAL_OUT_OE), .REG_RD_ADDR(REG_RD_ADDR), .REG_RD_DATA(REG_RD_DATA),
  .REG_WR(REG_WR), .CACHE_BUSY(CACHE_BUSY));
